// ===== include/seci_pkg.sv
// Package for the serial EEPROM command front end: opcodes, status layout, timing.
// Assumes a single 125 MHz system clock samples every pin of the serial link.
package seci_pkg;

  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned PROG_TIME_MS  = 5;
  localparam int unsigned PROG_CYCLES   = (PROG_TIME_MS * 1000000) / CLK_PERIOD_NS;

  // Opcodes with bit 3 masked off
  localparam logic [7:0] OPC_MASK     = 8'hF7;
  localparam logic [7:0] OPC_SET_WRL  = 8'h06;
  localparam logic [7:0] OPC_CLR_WRL  = 8'h04;
  localparam logic [7:0] OPC_STAT_RD  = 8'h05;
  localparam logic [7:0] OPC_STAT_WR  = 8'h01;
  localparam logic [7:0] OPC_ARR_RD   = 8'h03;
  localparam logic [7:0] OPC_ARR_WR   = 8'h02;

  // Status register bit positions
  localparam int unsigned ST_BUSY   = 0;
  localparam int unsigned ST_WRL    = 1;
  localparam int unsigned ST_BLK_LO = 2;
  localparam int unsigned ST_BLK_HI = 3;
  localparam int unsigned ST_ARM    = 7;
  localparam logic [7:0]  ST_ALL_ONES = 8'hFF;

  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] BLK_NONE = 2'h0;

  typedef enum logic [2:0] {
    SECI_IDLE,
    SECI_OPCODE,
    SECI_STAT_OUT,
    SECI_STAT_IN,
    SECI_STREAM,
    SECI_DEAD
  } seci_state_t;

  // Synchronised pin samples
  typedef struct packed {
    logic sel_n;
    logic sck;
    logic din;
    logic pause_n;
    logic prot_n;
  } seci_pins_t;

  typedef struct packed {
    seci_pins_t  s1;
    seci_pins_t  s2;
    logic        sck_d;
    logic        sel_n_d;
    seci_state_t st;
    logic [2:0]  bitcnt;
    logic [7:0]  shreg;
    logic [7:0]  txreg;
    logic        paused;
    logic        wr_latch;
    logic        arm;
    logic [1:0]  blk_lvl;
    logic        stat_wr_ok;
    logic [7:0]  stat_pend;
    logic        stat_done;
    logic        arr_pend;
    logic        busy;
    logic [31:0] prog_cnt;
    logic        dout;
    logic        dout_en;
    logic [7:0]  opcode;
    logic        arr_start;
  } seci_regs_t;

endpackage

// ===== logic/seci_core.sv
// Command front end of a byte-wide serial EEPROM acting as a serial link slave.
// Assumes the link pins are asynchronous to clk; the array itself lies outside.
//
// How it works
// - Serial clock is only sampled as an input; the block never drives it.
// - Bytes shift in and out most significant bit first.
// - First byte after select falls lands in an eight-bit opcode register.
// - Every command starts on a falling edge of chip select.
// - Unknown opcode: ignore input, output off until next select fall.
// - Deselected: input ignored, output held off.
// - Pause lowered while clock low freezes the sequence without losing state.
// - Pause raised while clock low resumes; clock edges while paused ignored.
// - Whenever output is off by pause or deselect, serial input is ignored.
// - Protect pin low with arm bit set blocks status writes.
// - Protect falling during status write aborts it; no effect once programming.
// - Arm bit clear makes the protect pin irrelevant.
// - Decode set and clear write-latch opcodes, bit 3 ignored.
// - Decode status read and status write opcodes, bit 3 ignored.
// - Decode array read and array write opcodes, bit 3 ignored.
// - Write latch clear at reset; programming refused unless latch set.
// - Clear-latch opcode works regardless of the protect pin.
// - Status: arm bit 7, bits 6..4 zero, block bits 3..2, latch 1, busy 0.
// - Status read reports busy and latch; block bits change only by status write.
// - Busy reads 1 while programming; all eight bits read 1 then.
// - Block bits pick none, upper quarter, upper half or whole array.
// - While programming only the status read opcode is accepted.
// - Write latch clears automatically when programming completes.
`timescale 1ns/10ps

module seci_core
  import seci_pkg::*;
#(
  parameter int unsigned PROG_LEN = PROG_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       sel_n,
  input  wire logic       sck,
  input  wire logic       din,
  input  wire logic       pause_n,
  input  wire logic       prot_n,
  output logic            dout,
  output logic            dout_en,
  output logic [7:0]      opcode,
  output logic            arr_rd_start,
  output logic            arr_wr_start,
  output logic [1:0]      blk_lvl,
  output logic            busy
);

  seci_regs_t r_r;
  seci_regs_t r_nxt;

  function automatic logic opc_is(input logic [7:0] code, input logic [7:0] pat);
    return (code & OPC_MASK) == pat;
  endfunction

  function automatic logic [7:0] status_of(input seci_regs_t s);
    logic [7:0] v;
    v = '0;
    if (s.busy) begin
      v = ST_ALL_ONES;
    end else begin
      v[ST_ARM]    = s.arm;
      v[ST_BLK_HI] = s.blk_lvl[1];
      v[ST_BLK_LO] = s.blk_lvl[0];
      v[ST_WRL]    = s.wr_latch;
      v[ST_BUSY]   = 1'b0;
    end
    return v;
  endfunction

  logic       sck_rise;
  logic       sck_fall;
  logic       sel_fall;
  logic       sel_rise;
  logic       active;
  logic [7:0] byte_in;
  logic       byte_end;
  logic       hw_prot;

  always_comb begin
    r_nxt          = r_r;
    r_nxt.s1       = '{sel_n, sck, din, pause_n, prot_n};
    r_nxt.s2       = r_r.s1;
    r_nxt.sck_d    = r_r.s2.sck;
    r_nxt.sel_n_d  = r_r.s2.sel_n;
    r_nxt.arr_start = 1'b0;
    sck_rise = r_r.s2.sck & ~r_r.sck_d;
    sck_fall = ~r_r.s2.sck & r_r.sck_d;
    sel_fall = ~r_r.s2.sel_n & r_r.sel_n_d;
    sel_rise = r_r.s2.sel_n & ~r_r.sel_n_d;
    hw_prot  = r_r.arm & ~r_r.s2.prot_n;
    byte_in  = {r_r.shreg[6:0], r_r.s2.din};
    byte_end = r_r.bitcnt == BIT_LAST;

    // Pause only changes state while the clock is low, so a glitching clock
    // during the pause cannot shift a bit.
    if (!r_r.s2.sck) begin
      r_nxt.paused = ~r_r.s2.pause_n;
    end
    active = ~r_r.s2.sel_n & ~r_r.paused & (r_r.st != SECI_DEAD);

    // Protect pin falling mid status write aborts it
    if (hw_prot) begin
      r_nxt.stat_wr_ok = 1'b0;
    end

    if (sel_fall) begin
      r_nxt.st     = SECI_OPCODE;
      r_nxt.bitcnt = '0;
      r_nxt.shreg  = '0;
    end else if (r_r.s2.sel_n) begin
      r_nxt.st     = SECI_IDLE;
      r_nxt.bitcnt = '0;
      if (sel_rise && r_r.st == SECI_STAT_IN && r_r.stat_done
          && r_r.stat_wr_ok && !hw_prot) begin
        r_nxt.arm        = r_r.stat_pend[ST_ARM];
        r_nxt.blk_lvl    = {r_r.stat_pend[ST_BLK_HI], r_r.stat_pend[ST_BLK_LO]};
        r_nxt.busy       = 1'b1;
        r_nxt.prog_cnt   = '0;
      end else if (sel_rise && r_r.arr_pend) begin
        r_nxt.busy     = 1'b1;
        r_nxt.prog_cnt = '0;
      end
      r_nxt.arr_pend  = 1'b0;
      r_nxt.stat_done = 1'b0;
    end else if (active && sck_rise) begin
      r_nxt.shreg  = byte_in;
      r_nxt.bitcnt = r_r.bitcnt + 3'h1;
      if (byte_end && r_r.st == SECI_OPCODE) begin
        r_nxt.opcode = byte_in;
        r_nxt.st     = SECI_DEAD;
        if (opc_is(byte_in, OPC_STAT_RD)) begin
          r_nxt.st    = SECI_STAT_OUT;
          r_nxt.txreg = status_of(r_r);
          // First bit stands before the first fall so a stale bit never shows
          r_nxt.dout  = r_nxt.txreg[BIT_LAST];
        end else if (r_r.busy) begin
          r_nxt.st = SECI_DEAD;
        end else if (opc_is(byte_in, OPC_SET_WRL)) begin
          r_nxt.wr_latch = 1'b1;
          r_nxt.st       = SECI_STREAM;
        end else if (opc_is(byte_in, OPC_CLR_WRL)) begin
          r_nxt.wr_latch = 1'b0;
          r_nxt.st       = SECI_STREAM;
        end else if (opc_is(byte_in, OPC_STAT_WR)) begin
          r_nxt.st         = SECI_STAT_IN;
          r_nxt.stat_wr_ok = r_r.wr_latch & ~hw_prot;
        end else if (opc_is(byte_in, OPC_ARR_RD)) begin
          r_nxt.st        = SECI_STREAM;
          r_nxt.arr_start = 1'b1;
        end else if (opc_is(byte_in, OPC_ARR_WR)) begin
          r_nxt.st        = SECI_STREAM;
          r_nxt.arr_start = 1'b1;
          r_nxt.arr_pend  = r_r.wr_latch;
        end else begin
          r_nxt.st = SECI_DEAD;
        end
      end else if (byte_end && r_r.st == SECI_STAT_IN && !r_r.stat_done) begin
        r_nxt.stat_pend = byte_in;
        r_nxt.stat_done = 1'b1;
      end else if (byte_end && r_r.st == SECI_STAT_OUT) begin
        r_nxt.txreg = status_of(r_r);
      end
    end else if (active && sck_fall && r_r.st == SECI_STAT_OUT) begin
      r_nxt.dout  = r_r.txreg[BIT_LAST - r_r.bitcnt];
    end

    // Output drives only for status read, selected and not paused
    r_nxt.dout_en = active & (r_r.st == SECI_STAT_OUT);
    if (r_r.st == SECI_STAT_OUT && r_nxt.st == SECI_STAT_OUT && r_nxt.bitcnt == '0
        && !sck_fall && r_r.bitcnt != r_nxt.bitcnt) begin
      r_nxt.dout = r_nxt.txreg[BIT_LAST];
    end

    if (r_r.busy) begin
      if (r_r.prog_cnt >= PROG_LEN - 1) begin
        r_nxt.busy     = 1'b0;
        r_nxt.wr_latch = 1'b0;
      end else begin
        r_nxt.prog_cnt = r_r.prog_cnt + 32'h1;
      end
    end

    if (!rst_n) begin
      r_nxt          = '0;
      r_nxt.s1       = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
      r_nxt.s2       = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
      r_nxt.sel_n_d  = 1'b1;
      r_nxt.st       = SECI_IDLE;
      r_nxt.wr_latch = 1'b0;
      r_nxt.blk_lvl  = BLK_NONE;
    end
  end

  always_ff @(posedge clk) begin
    r_r <= r_nxt;
  end

  assign dout         = r_r.dout;
  assign dout_en      = r_r.dout_en;
  assign opcode       = r_r.opcode;
  assign arr_rd_start = r_r.arr_start & opc_is(r_r.opcode, OPC_ARR_RD);
  assign arr_wr_start = r_r.arr_start & opc_is(r_r.opcode, OPC_ARR_WR);
  assign blk_lvl      = r_r.blk_lvl;
  assign busy         = r_r.busy;

endmodule

// ===== verif/seci_core_props.sv
// Checker for the serial command front end, watching the top module's ports only.
// Assumes the bench runs with a short programming length of at least 8 cycles.
`timescale 1ns/10ps
module seci_core_props
  import seci_pkg::*;
#(
  parameter int unsigned PROG_LEN = 20
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       sel_n,
  input wire logic       sck,
  input wire logic       din,
  input wire logic       pause_n,
  input wire logic       prot_n,
  input wire logic       dout,
  input wire logic       dout_en,
  input wire logic [7:0] opcode,
  input wire logic       arr_rd_start,
  input wire logic       arr_wr_start,
  input wire logic [1:0] blk_lvl,
  input wire logic       busy
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Six samples cover the two sync flops plus the output register
  sequence s_desel;
    sel_n [*6];
  endsequence
  sequence s_paused;
    !pause_n [*6];
  endsequence
  sequence s_prog;
    busy [*8];
  endsequence
  AST_DESEL_OFF: assert property (s_desel |-> !dout_en)
    else $error("output on while deselected");
  AST_PAUSE_OFF: assert property (s_paused |-> !dout_en)
    else $error("output on while paused");
  AST_EN_STAT: assert property ($rose(dout_en) |-> (opcode & OPC_MASK) == OPC_STAT_RD)
    else $error("output on without status read");
  AST_BUSY_ONES: assert property (busy && dout_en && $past(dout_en) |-> dout)
    else $error("status bit not one while busy");
  AST_ARR_RD: assert property (arr_rd_start |-> (opcode & OPC_MASK) == OPC_ARR_RD)
    else $error("array read start without opcode");
  AST_ARR_WR: assert property (arr_wr_start |-> (opcode & OPC_MASK) == OPC_ARR_WR && !busy)
    else $error("array write start wrong");
  AST_PROG_DESEL: assert property ($rose(busy) |-> sel_n && $past(sel_n, 2))
    else $error("programming began while selected");
  AST_PROG_HOLD: assert property ($rose(busy) |-> s_prog)
    else $error("busy too short");
  AST_BLK_STABLE: assert property ($changed(blk_lvl) |-> $past(busy) or (##[0:2] busy))
    else $error("block level changed outside write");
endmodule
bind seci_core seci_core_props #(.PROG_LEN(PROG_LEN)) i_seci_core_props (.clk, .rst_n,
  .sel_n, .sck, .din, .pause_n, .prot_n, .dout, .dout_en, .opcode, .arr_rd_start,
  .arr_wr_start, .blk_lvl, .busy);

// ===== verif/seci_master.sv
// Serial link master model: mode 0, 160 ns link clock made from the system clock.
// Assumes the caller enters its tasks just after a rising clk edge.
`timescale 1ns/10ps
module seci_master (
  input  wire logic clk,
  input  wire logic dout,
  output logic      sel_n,
  output logic      sck,
  output logic      din,
  output logic      pause_n
);
  initial begin
    sel_n = 1'b1;
    sck = 1'b0;
    din = 1'b0;
    pause_n = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic xfer(input logic [7:0] tx, input bit pz, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      if (pz && i == 3) begin
        pause_n <= 1'b0;
        hold(10);
        repeat (2) begin
          sck <= 1'b1;
          din <= ~din;
          hold(10);
          sck <= 1'b0;
          hold(10);
        end
        pause_n <= 1'b1;
        hold(10);
      end
      din <= tx[i];
      hold(10);
      rx[i] = dout;
      sck <= 1'b1;
      hold(10);
      sck <= 1'b0;
    end
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] w, input int n, input bit pz,
                     output logic [7:0] rd);
    sel_n <= 1'b0;
    hold(10);
    xfer(op, 1'b0, rd);
    repeat (n) xfer(w, pz, rd);
    hold(10);
    sel_n <= 1'b1;
    din <= ~din;
    hold(20);
  endtask
endmodule

// ===== verif/tb_top.sv
// Self-checking bench for the serial command front end with a master model.
// Assumes a programming length of 800 cycles so busy spans a status read.
`timescale 1ns/10ps
module tb_top;
  import seci_pkg::*;
  localparam int unsigned PLEN = 800;
  logic       clk, rst_n, prot_n, dout, dout_en, ard, awr, busy, sel_n, sck, din, pause_n;
  logic [7:0] opcode, rd, wd;
  logic [1:0] blk_lvl;
  int         n_fail = 0, n_tests = 0, seed = 40;
  int         n_ard = 0;
  int         n_awr = 0;
  seci_core #(.PROG_LEN(PLEN)) i_seci_core (.clk, .rst_n, .sel_n, .sck, .din, .pause_n,
    .prot_n, .dout, .dout_en, .opcode, .arr_rd_start(ard), .arr_wr_start(awr), .blk_lvl,
    .busy);
  seci_master i_seci_master (.clk, .dout, .sel_n, .sck, .din, .pause_n);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Count start pulses so each one-cycle strobe is seen while it stands
  always @(posedge clk) begin
    n_ard <= n_ard + int'(ard);
    n_awr <= n_awr + int'(awr);
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] st_exp(input logic [7:0] w);
    return {w[7], 3'h0, w[3:2], 2'h0};
  endfunction
  task automatic run(input logic [7:0] op, input logic [7:0] w, input int n, input bit pz);
    i_seci_master.cmd(op, w, n, pz, rd);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    conclude();
  end
  initial begin
    rst_n = 1'b0;
    prot_n = 1'b1;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    run(OPC_STAT_RD, 8'h00, 1, 0);
    check(rd, 8'h00);
    run(OPC_SET_WRL | 8'h08, 8'h00, 0, 0);
    run(OPC_STAT_RD, 8'h00, 1, 1);
    check(rd, 8'h02);
    prot_n <= 1'b0;
    run(OPC_CLR_WRL | 8'h08, 8'h00, 0, 0);
    run(OPC_STAT_RD | 8'h08, 8'h00, 1, 0);
    check(rd, 8'h00);
    // Arm bit kept clear so the low protect pin must not matter
    repeat (4) begin
      wd = 8'($random(seed)) & 8'h7F;
      run(OPC_SET_WRL, 8'h00, 0, 0);
      run(OPC_STAT_WR | 8'h08, wd, 2, 0);
      run(OPC_SET_WRL, 8'h00, 0, 0);
      run(OPC_STAT_RD, 8'h00, 1, 0);
      check(rd, ST_ALL_ONES);
      repeat (PLEN) @(posedge clk);
      run(OPC_STAT_RD, 8'h00, 1, 0);
      check(rd, st_exp(wd));
      check({6'h0, blk_lvl}, {6'h0, wd[3:2]});
    end
    prot_n <= 1'b1;
    run(OPC_SET_WRL, 8'h00, 0, 0);
    run(OPC_STAT_WR, 8'h8C, 1, 0);
    repeat (PLEN) @(posedge clk);
    prot_n <= 1'b0;
    run(OPC_SET_WRL, 8'h00, 0, 0);
    run(OPC_STAT_WR, 8'h00, 1, 0);
    repeat (PLEN) @(posedge clk);
    check({6'h0, blk_lvl}, 8'h03);
    prot_n <= 1'b1;
    run(8'hFF, 8'h00, 1, 0);
    check(opcode, 8'hFF);
    check(8'(n_ard + n_awr), 8'h00);
    run(OPC_ARR_RD, 8'h00, 1, 0);
    check(8'(n_ard), 8'h01);
    run(OPC_CLR_WRL, 8'h00, 0, 0);
    run(OPC_ARR_WR, 8'h5A, 3, 0);
    check(8'(n_awr), 8'h01);
    check({7'h0, busy}, 8'h00);
    conclude();
  end
endmodule
